/* hw/mcsel_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the
// main clock selector. Included by the meter and top design files; definitions only.
`ifndef MCSEL_CFG_SVH
`define MCSEL_CFG_SVH

// Byte offsets on the register bus.
`define MCSEL_OFF_OSC_CFG    5'h00
`define MCSEL_OFF_FREQ       5'h04
`define MCSEL_OFF_PLL_CFG    5'h08
`define MCSEL_OFF_MCK_CFG    5'h0c
`define MCSEL_OFF_STATUS     5'h10
`define MCSEL_OFF_MASK       5'h14

// Main oscillator configuration fields.
`define MCSEL_RC_EN_BIT      0
`define MCSEL_RC_FREQ_LO     1
`define MCSEL_XT_EN_BIT      3
`define MCSEL_XT_CNT_LO      8
`define MCSEL_SEL_BIT        16

// Frequency counter fields.
`define MCSEL_FREQ_RDY_BIT   16
`define MCSEL_FREQ_RST_BIT   20

// PLL and main clock configuration fields.
`define MCSEL_PLL_DIV_LO     0
`define MCSEL_PLL_CNT_LO     8
`define MCSEL_PLL_MUL_LO     16
`define MCSEL_MCK_HALVE_BIT  0

// Status and mask bit positions.
`define MCSEL_ST_XT_STABLE   0
`define MCSEL_ST_PLL_READY   1
`define MCSEL_ST_SEL_DONE    3
`define MCSEL_ST_RC_STABLE   4
`define MCSEL_ST_MEAS_READY  5

// Reset values.
`define MCSEL_RST_RC_EN      1'b1
`define MCSEL_RST_RC_FREQ    2'h0

// Timing counts.
`define MCSEL_RC_SETTLE      4'h4
`define MCSEL_XT_PRESCALE    3'h7
`define MCSEL_MEAS_PERIODS   5'h10

`endif

/* hw/mcsel_freq_meter.sv */
// Main clock frequency meter: counts main clock rising edges over a fixed
// number of slow clock periods. Edge pulses arrive in the system clock domain.
`timescale 1ns/100ps
`include "mcsel_cfg.svh"
module mcsel_freq_meter (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        start_in,
   input  wire logic        main_rise_in,
   input  wire logic        slow_rise_in,
   input  wire logic        slow_fall_in,
   output logic [15:0]      count_out,
   output logic             ready_out
);
   logic       pend_reg;
   logic       run_reg;
   logic [4:0] falls_reg;

   wire last_fall = slow_fall_in &&
                    (falls_reg == `MCSEL_MEAS_PERIODS - 5'h01);

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pend_reg  <= 1'b0;
         run_reg   <= 1'b0;
         falls_reg <= 5'h00;
         count_out <= 16'h0000;
         ready_out <= 1'b0;
      end else if (start_in) begin
         pend_reg  <= 1'b1;
         run_reg   <= 1'b0;
         ready_out <= 1'b0;
      end else if (pend_reg && slow_rise_in) begin
         pend_reg  <= 1'b0;
         run_reg   <= 1'b1;
         falls_reg <= 5'h00;
         count_out <= 16'h0000;
      end else if (run_reg) begin
         if (main_rise_in) begin
            count_out <= count_out + 16'h0001;
         end
         if (slow_fall_in) begin
            falls_reg <= falls_reg + 5'h01;
         end
         if (last_fall) begin
            run_reg   <= 1'b0;
            ready_out <= 1'b1;
         end
      end
   end
endmodule

/* hw/mcsel_pkg.sv */
// Types shared by the main clock selector design files.
// Assumes the constants of mcsel_cfg.svh are included where needed.
package mcsel_pkg;

   typedef enum logic [2:0] {
      MCSEL_SW_RUN   = 3'b001,
      MCSEL_SW_DRAIN = 3'b010,
      MCSEL_SW_ARM   = 3'b100
   } mcsel_sw_state_t;

endpackage

/* hw/mcsel_top.sv */
// Main clock source selection, frequency meter and PLL control with an
// Avalon-MM register slave. Oscillator, slow and PLL clocks arrive as
// signals that are oversampled by the 50 MHz system clock.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "mcsel_cfg.svh"
module mcsel_top (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        slow_clock_in,
   input  wire logic        fast_rc_clk_in,
   input  wire logic        crystal_clk_in,
   input  wire logic        pll_clock_in,
   input  wire logic        wait_mode_in,
   output logic             main_clock_out,
   output logic             pll_ref_clock_out,
   output logic             pll_clock_out,
   output logic             pll_enable_out,
   output logic [10:0]      pll_feedback_factor_out,
   output logic [7:0]       pll_divider_out,
   output logic             fast_rc_enable_out,
   output logic [1:0]       fast_rc_freq_select_out,
   output logic             crystal_osc_enable_out,
   output logic             irq_out
);
   function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic rise(input logic now_v, input logic old_v);
      return now_v & ~old_v;
   endfunction

   // Synchronisers: bit 0 slow, 1 RC, 2 crystal, 3 PLL.
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] s3_reg;

   logic        sel_reg;
   logic        cur_sel_reg;
   logic [7:0]  xt_cnt_reg;
   logic [7:0]  xt_left_reg;
   logic [2:0]  xt_pre_reg;
   logic        xt_stable_reg;
   logic [3:0]  rc_left_reg;
   logic        rc_stable_reg;
   logic [5:0]  pcnt_reg;
   logic [5:0]  lock_left_reg;
   logic        lock_reg;
   logic [7:0]  pdiv_cnt_reg;
   logic        half_reg;
   logic        halve_reg;
   logic [5:0]  mask_reg;
   logic        rcs_d_reg;
   logic        xts_d_reg;
   logic        sel_d_reg;
   mcsel_pkg::mcsel_sw_state_t sw_reg;
   mcsel_pkg::mcsel_sw_state_t sw_next;
   logic [15:0] meas_count;
   logic        meas_ready;

   // Bus decode.
   wire req   = avs_read_in | avs_write_in;
   wire do_wr = avs_write_in & ~avs_waitrequest_out;
   wire a_osc = avs_address_in == `MCSEL_OFF_OSC_CFG;
   wire a_frq = avs_address_in == `MCSEL_OFF_FREQ;
   wire a_pll = avs_address_in == `MCSEL_OFF_PLL_CFG;
   wire a_mck = avs_address_in == `MCSEL_OFF_MCK_CFG;
   wire a_st  = avs_address_in == `MCSEL_OFF_STATUS;
   wire a_msk = avs_address_in == `MCSEL_OFF_MASK;

   wire sel_done = (sw_reg == mcsel_pkg::MCSEL_SW_RUN) &&
                   (cur_sel_reg == sel_reg);
   wire [5:0] status = {meas_ready, rc_stable_reg, sel_done, 1'b0,
                        lock_reg, xt_stable_reg};

   wire [31:0] osc_word = {15'h0000, sel_reg, xt_cnt_reg, 4'h0,
                           crystal_osc_enable_out,
                           fast_rc_freq_select_out, fast_rc_enable_out};
   wire [31:0] frq_word = {15'h0000, meas_ready, meas_count};
   wire [31:0] pll_word = {5'h00, pll_feedback_factor_out, 2'h0, pcnt_reg,
                           pll_divider_out};
   wire [31:0] rd_word  = a_osc ? osc_word :
                          a_frq ? frq_word :
                          a_pll ? pll_word :
                          a_mck ? {31'h00000000, halve_reg} :
                          a_st  ? {26'h0000000, status} :
                          a_msk ? {26'h0000000, mask_reg} : 32'h00000000;
   wire [31:0] wm = be_merge(rd_word, avs_writedata_in, avs_byteenable_in);

   wire wr_osc = do_wr & a_osc;
   wire wr_pll = do_wr & a_pll;

   // Oscillator configuration next values; wait mode forces the RC source.
   wire       rc_en_n   = wait_mode_in | (wr_osc ? wm[`MCSEL_RC_EN_BIT]
                                                 : fast_rc_enable_out);
   wire [1:0] rc_frq_n  = wr_osc ? wm[`MCSEL_RC_FREQ_LO +: 2]
                                 : fast_rc_freq_select_out;
   wire       xt_en_n   = wr_osc ? wm[`MCSEL_XT_EN_BIT]
                                 : crystal_osc_enable_out;
   wire       sel_n     = ~wait_mode_in & (wr_osc ? wm[`MCSEL_SEL_BIT]
                                                  : sel_reg);
   wire rc_restart = (rc_frq_n != fast_rc_freq_select_out) |
                     rise(rc_en_n, fast_rc_enable_out);
   wire xt_restart = rise(xt_en_n, crystal_osc_enable_out);

   // PLL configuration next values.
   wire [7:0]  div_n  = wr_pll ? wm[`MCSEL_PLL_DIV_LO +: 8] : pll_divider_out;
   wire [10:0] mul_n  = wr_pll ? wm[`MCSEL_PLL_MUL_LO +: 11]
                               : pll_feedback_factor_out;
   wire [5:0]  pcnt_n = wr_pll ? wm[`MCSEL_PLL_CNT_LO +: 6] : pcnt_reg;
   wire        pll_on_n = (|mul_n) | (|div_n);
   wire pll_restart = pll_on_n & ((div_n != pll_divider_out) |
                      (mul_n != pll_feedback_factor_out) |
                      ~pll_enable_out);

   // Slow clock events.
   wire slow_rise = rise(s2_reg[0], s3_reg[0]);
   wire slow_fall = rise(s3_reg[0], s2_reg[0]);
   wire xt_tick   = slow_rise && (xt_pre_reg == `MCSEL_XT_PRESCALE);

   // Glitch-free main clock switch.
   wire src_cur  = cur_sel_reg ? s2_reg[2] : s2_reg[1];
   wire tgt_rise = sel_reg ? rise(s2_reg[2], s3_reg[2])
                           : rise(s2_reg[1], s3_reg[1]);
   wire cur_rise = cur_sel_reg ? rise(s2_reg[2], s3_reg[2])
                               : rise(s2_reg[1], s3_reg[1]);
   wire rc_hold  = ~cur_sel_reg & ~rc_stable_reg;
   // A pulse only starts on a source rising edge and then follows the source
   // down, so neither a switch nor a hold can shorten it.
   wire main_n   = main_clock_out ? src_cur :
                   (cur_rise & ~rc_hold &
                    (sw_reg == mcsel_pkg::MCSEL_SW_RUN));
   wire main_rise = rise(main_n, main_clock_out);

   always_comb begin
      sw_next = sw_reg;
      unique case (sw_reg)
         mcsel_pkg::MCSEL_SW_RUN: begin
            if (sel_reg != cur_sel_reg) begin
               sw_next = mcsel_pkg::MCSEL_SW_DRAIN;
            end
         end
         mcsel_pkg::MCSEL_SW_DRAIN: begin
            if (!main_clock_out) begin
               sw_next = mcsel_pkg::MCSEL_SW_ARM;
            end
         end
         mcsel_pkg::MCSEL_SW_ARM: begin
            if (tgt_rise) begin
               sw_next = mcsel_pkg::MCSEL_SW_RUN;
            end
         end
      endcase
   end

   // PLL input divider and output halving.
   wire [7:0] pdiv_wrap = pll_divider_out - 8'h01;
   wire [7:0] pdiv_cnt_n = !main_rise ? pdiv_cnt_reg :
                           (pdiv_cnt_reg >= pdiv_wrap) ? 8'h00 :
                           pdiv_cnt_reg + 8'h01;
   wire ref_lvl = (pll_divider_out == 8'h00) ? 1'b0 :
                  (pll_divider_out == 8'h01) ? main_n :
                  (pdiv_cnt_n < {1'b0, pll_divider_out[7:1]});
   // The reference only rises with the main clock, so a divider write in
   // mid-period cannot start a short pulse.
   wire ref_n = pll_ref_clock_out ? ref_lvl : (ref_lvl & main_rise);
   wire pll_rise = rise(s2_reg[3], s3_reg[3]);
   wire pll_n = (pll_divider_out != 8'h00) & pll_enable_out &
                (halve_reg ? half_reg : s2_reg[3]);

   wire meas_start = (do_wr & a_frq & wm[`MCSEL_FREQ_RST_BIT]) |
                     (rc_stable_reg & ~rcs_d_reg & ~cur_sel_reg) |
                     (xt_stable_reg & ~xts_d_reg & cur_sel_reg) |
                     (sel_reg ^ sel_d_reg);

   mcsel_freq_meter u_meter (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .start_in     (meas_start),
      .main_rise_in (main_rise),
      .slow_rise_in (slow_rise),
      .slow_fall_in (slow_fall),
      .count_out    (meas_count),
      .ready_out    (meas_ready)
   );

   // Bus slave: one wait cycle, then the answer for one cycle.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h00000000;
      end else begin
         avs_waitrequest_out <= ~(req & avs_waitrequest_out);
         if (avs_read_in & avs_waitrequest_out) begin
            avs_readdata_out <= rd_word;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
      end else begin
         s1_reg <= {pll_clock_in, crystal_clk_in, fast_rc_clk_in,
                    slow_clock_in};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Configuration registers.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         fast_rc_enable_out      <= `MCSEL_RST_RC_EN;
         fast_rc_freq_select_out <= `MCSEL_RST_RC_FREQ;
         crystal_osc_enable_out  <= 1'b0;
         xt_cnt_reg              <= 8'h00;
         sel_reg                 <= 1'b0;
         pll_divider_out         <= 8'h00;
         pll_feedback_factor_out <= 11'h000;
         pcnt_reg                <= 6'h00;
         pll_enable_out          <= 1'b0;
         halve_reg               <= 1'b0;
         mask_reg                <= 6'h00;
      end else begin
         fast_rc_enable_out      <= rc_en_n;
         fast_rc_freq_select_out <= rc_frq_n;
         crystal_osc_enable_out  <= xt_en_n;
         sel_reg                 <= sel_n;
         pll_divider_out         <= div_n;
         pll_feedback_factor_out <= mul_n;
         pcnt_reg                <= pcnt_n;
         pll_enable_out          <= pll_on_n;
         if (wr_osc) begin
            xt_cnt_reg <= wm[`MCSEL_XT_CNT_LO +: 8];
         end
         if (do_wr & a_mck) begin
            halve_reg <= wm[`MCSEL_MCK_HALVE_BIT];
         end
         if (do_wr & a_msk) begin
            mask_reg <= wm[5:0];
         end
      end
   end

   // Fast RC settle counter on slow clock cycles.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rc_left_reg   <= `MCSEL_RC_SETTLE;
         rc_stable_reg <= 1'b0;
      end else if (!rc_en_n || rc_restart) begin
         rc_left_reg   <= `MCSEL_RC_SETTLE;
         rc_stable_reg <= 1'b0;
      end else if (!rc_stable_reg && slow_rise) begin
         if (rc_left_reg == 4'h0) begin
            rc_stable_reg <= 1'b1;
         end else begin
            rc_left_reg <= rc_left_reg - 4'h1;
         end
      end
   end

   // Crystal start-up counter on slow clock divided by eight.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         xt_left_reg   <= 8'h00;
         xt_pre_reg    <= 3'h0;
         xt_stable_reg <= 1'b0;
      end else if (!xt_en_n || xt_restart) begin
         xt_left_reg   <= wr_osc ? wm[`MCSEL_XT_CNT_LO +: 8] : xt_cnt_reg;
         xt_pre_reg    <= 3'h0;
         xt_stable_reg <= 1'b0;
      end else if (!xt_stable_reg) begin
         if (slow_rise) begin
            xt_pre_reg <= xt_pre_reg + 3'h1;
         end
         if (xt_tick) begin
            if (xt_left_reg == 8'h00) begin
               xt_stable_reg <= 1'b1;
            end else begin
               xt_left_reg <= xt_left_reg - 8'h01;
            end
         end
      end
   end

   // PLL lock counter on slow clock cycles.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         lock_left_reg <= 6'h00;
         lock_reg      <= 1'b0;
      end else if (!pll_on_n || pll_restart) begin
         lock_left_reg <= pcnt_n;
         lock_reg      <= 1'b0;
      end else if (!lock_reg && slow_rise) begin
         if (lock_left_reg == 6'h00) begin
            lock_reg <= 1'b1;
         end else begin
            lock_left_reg <= lock_left_reg - 6'h01;
         end
      end
   end

   // Clock outputs, switch state and interrupt.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sw_reg            <= mcsel_pkg::MCSEL_SW_RUN;
         cur_sel_reg       <= 1'b0;
         main_clock_out    <= 1'b0;
         pdiv_cnt_reg      <= 8'h00;
         pll_ref_clock_out <= 1'b0;
         half_reg          <= 1'b0;
         pll_clock_out     <= 1'b0;
         rcs_d_reg         <= 1'b0;
         xts_d_reg         <= 1'b0;
         sel_d_reg         <= 1'b0;
         irq_out           <= 1'b0;
      end else begin
         sw_reg         <= sw_next;
         main_clock_out <= main_n;
         if (sw_reg == mcsel_pkg::MCSEL_SW_ARM && tgt_rise) begin
            cur_sel_reg <= sel_reg;
         end
         pdiv_cnt_reg <= pdiv_cnt_n;
         pll_ref_clock_out <= ref_n;
         if (pll_rise) begin
            half_reg <= ~half_reg;
         end
         pll_clock_out <= pll_n;
         rcs_d_reg     <= rc_stable_reg;
         xts_d_reg     <= xt_stable_reg;
         sel_d_reg     <= sel_reg;
         irq_out       <= |(status & mask_reg);
      end
   end
endmodule

/* tb/mcsel_checker.sv */
// Concurrent checks on the ports of the main clock selector.
// Assumes it is bound into mcsel_top and sees only that module's ports.
`timescale 1ns/100ps
module mcsel_checker (
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic        avs_waitrequest_out,
   input wire logic        wait_mode_in,
   input wire logic        main_clock_out,
   input wire logic        pll_ref_clock_out,
   input wire logic        pll_clock_out,
   input wire logic        pll_enable_out,
   input wire logic [10:0] pll_feedback_factor_out,
   input wire logic [7:0]  pll_divider_out,
   input wire logic        fast_rc_enable_out,
   input wire logic [1:0]  fast_rc_freq_select_out,
   input wire logic        crystal_osc_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence s_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_ans;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   a_bus_answer:
      assert property (s_req |=> s_ans) else $error("bus answer late");
   a_clock_no_glitch:
      assert property ($rose(main_clock_out) |=> main_clock_out)
      else $error("main clock pulse cut short");
   a_wait_forces_rc:
      assert property (wait_mode_in [*3] |-> fast_rc_enable_out)
      else $error("wait mode left rc disabled");
   a_reset_state:
      assert property ($fell(rst_in) |-> fast_rc_enable_out &&
         fast_rc_freq_select_out == 2'h0 && !crystal_osc_enable_out &&
         pll_divider_out == 8'h00) else $error("bad state after reset");
   a_div_zero_low:
      assert property ((pll_divider_out == 8'h00) [*3] |->
         !pll_ref_clock_out && !pll_clock_out)
      else $error("clock runs with divider zero");
   a_pll_off_low:
      assert property (!pll_enable_out [*3] |-> !pll_clock_out)
      else $error("pll clock runs while disabled");
   a_pll_enable_match:
      assert property ($stable(pll_feedback_factor_out) &&
         $stable(pll_divider_out) |-> pll_enable_out ==
         (pll_feedback_factor_out != 11'h0 || pll_divider_out != 8'h00))
      else $error("pll enable disagrees with fields");
   a_rc_change_stop:
      assert property ($changed(fast_rc_freq_select_out) &&
         fast_rc_enable_out && fast_rc_enable_out == 1'b1 |->
         ##5 !main_clock_out [*8]) else $error("main clock ran unsettled");
   a_ref_no_glitch:
      assert property ($rose(pll_ref_clock_out) |=> pll_ref_clock_out)
      else $error("reference clock pulse cut short");
endmodule
bind mcsel_top mcsel_checker u_mcsel_checker (.clk_sys_in, .rst_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .wait_mode_in,
   .main_clock_out, .pll_ref_clock_out, .pll_clock_out, .pll_enable_out,
   .pll_feedback_factor_out, .pll_divider_out, .fast_rc_enable_out,
   .fast_rc_freq_select_out, .crystal_osc_enable_out);

/* tb/mcsel_top_bench.sv */
// Self-checking bench for the main clock selector over its register bus.
// Assumes oscillator inputs are made here as sampled waveforms.
`timescale 1ns/100ps
module mcsel_top_bench;
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [4:0]  avs_address_in = 5'h00;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out, slow_clock_in = 1'b0;
   logic        fast_rc_clk_in = 1'b0, crystal_clk_in = 1'b0;
   logic        pll_clock_in = 1'b0, wait_mode_in = 1'b0, xtal_on = 1'b0;
   logic        main_clock_out, pll_ref_clock_out, pll_clock_out;
   logic        pll_enable_out, fast_rc_enable_out, crystal_osc_enable_out;
   logic        irq_out;
   logic [10:0] pll_feedback_factor_out;
   logic [7:0]  pll_divider_out, cyc = 8'h00;
   logic [2:0]  ph = 3'h0;
   logic [1:0]  fast_rc_freq_select_out;
   logic [31:0] q;
   int          fail_count = 0, samples_checked = 0, n;
   mcsel_top u_mcsel_top (
      .clk_sys_in              (clk_sys_in),
      .rst_in                  (rst_in),
      .avs_address_in          (avs_address_in),
      .avs_read_in             (avs_read_in),
      .avs_write_in            (avs_write_in),
      .avs_writedata_in        (avs_writedata_in),
      .avs_byteenable_in       (avs_byteenable_in),
      .avs_readdata_out        (avs_readdata_out),
      .avs_waitrequest_out     (avs_waitrequest_out),
      .slow_clock_in           (slow_clock_in),
      .fast_rc_clk_in          (fast_rc_clk_in),
      .crystal_clk_in          (crystal_clk_in),
      .pll_clock_in            (pll_clock_in),
      .wait_mode_in            (wait_mode_in),
      .main_clock_out          (main_clock_out),
      .pll_ref_clock_out       (pll_ref_clock_out),
      .pll_clock_out           (pll_clock_out),
      .pll_enable_out          (pll_enable_out),
      .pll_feedback_factor_out (pll_feedback_factor_out),
      .pll_divider_out         (pll_divider_out),
      .fast_rc_enable_out      (fast_rc_enable_out),
      .fast_rc_freq_select_out (fast_rc_freq_select_out),
      .crystal_osc_enable_out  (crystal_osc_enable_out),
      .irq_out                 (irq_out)
   );
   always #10 clk_sys_in = ~clk_sys_in;
   // Slow clock 16 cycles, RC and PLL 4 cycles, crystal 6 cycles a period.
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 8'h01;
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      slow_clock_in <= cyc[3];
      fast_rc_clk_in <= cyc[1];
      pll_clock_in <= cyc[1];
      crystal_clk_in <= xtal_on && crystal_osc_enable_out && ph < 3'h3;
   end
   task end_sim;
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= ~w;
      avs_write_in <= w;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0 && k < 100) begin
         k++;
         @(posedge clk_sys_in);
      end
      if (k == 100) begin
         chk(32'h1, 32'h0);
         end_sim();
      end
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task poll(input logic [4:0] a, input int b, input logic v);
      int k;
      k = 0;
      bus(1'b0, a, 32'h0);
      while (q[b] !== v && k < 1500) begin
         k++;
         bus(1'b0, a, 32'h0);
      end
      chk(32'(q[b]), 32'(v));
      if (q[b] !== v) end_sim();
   endtask
   task rises(input logic ref_sel, output int r);
      logic p, c;
      r = 0;
      p = 1'b1;
      repeat (64) begin
         @(negedge clk_sys_in);
         c = ref_sel ? pll_ref_clock_out : pll_clock_out;
         if (c && !p) r++;
         p = c;
      end
   endtask
   task in_range(input int v, input int lo, input int hi);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask
   task t_reset;
      rchk(5'h00, 32'hffffffff, 32'h1);
      rchk(5'h08, 32'hffffffff, 32'h0);
      rchk(5'h18, 32'hffffffff, 32'h0);
      @(negedge clk_sys_in);
      chk(32'(pll_ref_clock_out), 32'h0);
   endtask
   task t_rc;
      poll(5'h10, 4, 1'b1);
      bus(1'b1, 5'h00, 32'h3);
      rchk(5'h10, 32'h10, 32'h0);
      @(negedge clk_sys_in);
      chk(32'(fast_rc_freq_select_out), 32'h1);
      poll(5'h10, 4, 1'b1);
      bus(1'b1, 5'h04, 32'h0010_0000);
      rchk(5'h04, 32'h0001_0000, 32'h0);
      poll(5'h04, 16, 1'b1);
      in_range(int'(q[15:0]), 62, 64);
   endtask
   task t_xtal;
      bus(1'b1, 5'h00, 32'h020b);
      rchk(5'h10, 32'h1, 32'h0);
      repeat (200) @(posedge clk_sys_in);
      rchk(5'h10, 32'h1, 32'h0);
      poll(5'h10, 0, 1'b1);
      bus(1'b1, 5'h00, 32'h0001_020b);
      rchk(5'h00, 32'h0001_0000, 32'h0001_0000);
      repeat (100) @(posedge clk_sys_in);
      rchk(5'h10, 32'h8, 32'h0);
      bus(1'b1, 5'h00, 32'h020b);
      poll(5'h10, 3, 1'b1);
      xtal_on <= 1'b1;
      bus(1'b1, 5'h14, 32'h8);
      bus(1'b1, 5'h00, 32'h0001_020b);
      poll(5'h10, 3, 1'b1);
      repeat (3) @(negedge clk_sys_in);
      chk(32'(irq_out), 32'h1);
      bus(1'b1, 5'h14, 32'h0);
      repeat (3) @(negedge clk_sys_in);
      chk(32'(irq_out), 32'h0);
      bus(1'b1, 5'h04, 32'h0010_0000);
      poll(5'h04, 16, 1'b1);
      in_range(int'(q[15:0]), 40, 43);
      bus(1'b1, 5'h00, 32'h020b);
      poll(5'h10, 3, 1'b1);
   endtask
   task t_pll;
      bus(1'b1, 5'h08, 32'h0005_0302);
      rchk(5'h10, 32'h2, 32'h0);
      @(negedge clk_sys_in);
      chk(32'(pll_feedback_factor_out), 32'h5);
      chk(32'(pll_divider_out), 32'h2);
      poll(5'h10, 1, 1'b1);
      rises(1'b0, n);
      in_range(n, 15, 17);
      bus(1'b1, 5'h0c, 32'h1);
      rchk(5'h0c, 32'h1, 32'h1);
      rises(1'b0, n);
      in_range(n, 7, 9);
      bus(1'b1, 5'h0c, 32'h0);
      bus(1'b1, 5'h08, 32'h0005_0300);
      rises(1'b1, n);
      chk(32'(n), 32'h0);
      bus(1'b1, 5'h08, 32'h0300);
      repeat (4) @(negedge clk_sys_in);
      chk(32'(pll_enable_out), 32'h0);
      rchk(5'h10, 32'h2, 32'h0);
      bus(1'b1, 5'h08, 32'h0005_0301);
      repeat (4) @(negedge clk_sys_in);
      chk(32'(pll_enable_out), 32'h1);
      poll(5'h10, 1, 1'b1);
   endtask
   task t_wait;
      bus(1'b1, 5'h00, 32'h0001_0000);
      wait_mode_in <= 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk(32'(fast_rc_enable_out), 32'h1);
      rchk(5'h00, 32'h0001_0001, 32'h1);
      wait_mode_in <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reset();
      t_rc();
      t_xtal();
      t_pll();
      t_wait();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      fail_count++;
      end_sim();
   end
endmodule
